//--- rtl/urd_regs.vh
`ifndef URD_REGS_VH
`define URD_REGS_VH

// Register offsets on the three address lines
`define URD_ADDR_HOLD 3'h0
`define URD_ADDR_IEN 3'h1
`define URD_ADDR_INTFIFO 3'h2
`define URD_ADDR_LINE 3'h3

// Line control fields and special value
`define URD_LINE_DIVACC_BIT 7
`define URD_LINE_ENHANCED 8'hbf

// Reset value of every writable register, all-zero divisor value, and read byte for unmapped targets
`define URD_RESET_BYTE 8'h00
`define URD_DIV_ZERO 8'h00
`define URD_READ_NONE 8'h00

// Identity codes: values are arbitrary
`define URD_REVISION_CODE 8'h5a
`define URD_DEVICE_ID_CODE 8'ha5

// Target codes of the address select
`define URD_SEL_W 4
`define URD_SEL_NONE 4'h0
`define URD_SEL_RXHOLD 4'h1
`define URD_SEL_TXHOLD 4'h2
`define URD_SEL_DIVLO 4'h3
`define URD_SEL_DIVHI 4'h4
`define URD_SEL_REVISION 4'h5
`define URD_SEL_DEVID 4'h6
`define URD_SEL_INTEN 4'h7
`define URD_SEL_INTSTAT 4'h8
`define URD_SEL_FIFOCTL 4'h9
`define URD_SEL_LINECTL 4'ha
`define URD_SEL_ENHFUNC 4'hb

`endif

//--- rtl/urd_addr_select.v
`include "urd_regs.vh"
`default_nettype none

module urd_addr_select (
   input wire [2:0] addr,
   input wire [7:0] lineControl,
   input wire divisorZero,
   output reg [3:0] readSel,
   output reg [3:0] writeSel
);

   wire divAccess = lineControl[`URD_LINE_DIVACC_BIT];
   wire enhanced = (lineControl == `URD_LINE_ENHANCED);

   always @* begin
      readSel = `URD_SEL_NONE;
      writeSel = `URD_SEL_NONE;
      case (addr)
         `URD_ADDR_HOLD: begin
            if (!divAccess) begin
               readSel = `URD_SEL_RXHOLD;
               writeSel = `URD_SEL_TXHOLD;
            end else begin
               readSel = divisorZero ? `URD_SEL_REVISION : `URD_SEL_DIVLO;
               writeSel = `URD_SEL_DIVLO;
            end
         end
         `URD_ADDR_IEN: begin
            if (!divAccess) begin
               readSel = `URD_SEL_INTEN;
               writeSel = `URD_SEL_INTEN;
            end else begin
               readSel = divisorZero ? `URD_SEL_DEVID : `URD_SEL_DIVHI;
               writeSel = `URD_SEL_DIVHI;
            end
         end
         `URD_ADDR_INTFIFO: begin
            if (enhanced) begin
               readSel = `URD_SEL_ENHFUNC;
               writeSel = `URD_SEL_ENHFUNC;
            end else begin
               readSel = `URD_SEL_INTSTAT;
               writeSel = `URD_SEL_FIFOCTL;
            end
         end
         `URD_ADDR_LINE: begin
            readSel = `URD_SEL_LINECTL;
            writeSel = `URD_SEL_LINECTL;
         end
         default: begin
            // Upper half of the map lives elsewhere
            readSel = `URD_SEL_NONE;
            writeSel = `URD_SEL_NONE;
         end
      endcase
   end

endmodule

`default_nettype wire

//--- rtl/urd_register_decode.v
`include "urd_regs.vh"
`default_nettype none

module urd_register_decode (
   input wire clk,
   input wire nrst,
   input wire csN,
   input wire iorN,
   input wire iowN,
   input wire [2:0] addr,
   input wire [7:0] dataIn,
   output reg [7:0] dataOut,
   output reg dataOe,
   input wire [7:0] rxHoldingIn,
   input wire [7:0] interruptStatusIn,
   output reg rxHoldingRead,
   output reg interruptStatusRead,
   output reg [7:0] txHolding,
   output reg txHoldingLoad,
   output reg [7:0] fifoControl,
   output reg fifoControlLoad,
   output wire [7:0] divisorLow,
   output wire [7:0] divisorHigh,
   output wire [7:0] interruptEnable,
   output wire [7:0] lineControl,
   output wire [7:0] enhancedFunction
);

   ////////////////////////////////////////////////////////////////
   // Access detection

   reg readAct_q;
   reg writeAct_q;
   reg [7:0] divLo_q;
   reg [7:0] divHi_q;
   reg [7:0] intEn_q;
   reg [7:0] lineCtl_q;
   reg [7:0] enhFunc_q;
   wire [3:0] readSel;
   wire [3:0] writeSel;

   // Strobes only count while chip select is low
   wire readAct = !csN && !iorN;
   wire writeAct = !csN && !iowN;

   // One access per strobe, so side effects fire once
   wire readStart = readAct && !readAct_q;
   wire writeStart = writeAct && !writeAct_q;

   wire divisorZero = (divLo_q == `URD_DIV_ZERO) && (divHi_q == `URD_DIV_ZERO);

   urd_addr_select u_urd_addr_select (
      .addr(addr),
      .lineControl(lineCtl_q),
      .divisorZero(divisorZero),
      .readSel(readSel),
      .writeSel(writeSel)
   );

   always @(posedge clk) begin
      if (!nrst) begin
         readAct_q <= 1'b0;
         writeAct_q <= 1'b0;
      end else begin
         readAct_q <= readAct;
         writeAct_q <= writeAct;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Writes

   always @(posedge clk) begin
      if (!nrst) begin
         divLo_q <= `URD_RESET_BYTE;
         divHi_q <= `URD_RESET_BYTE;
         intEn_q <= `URD_RESET_BYTE;
         lineCtl_q <= `URD_RESET_BYTE;
         enhFunc_q <= `URD_RESET_BYTE;
         txHolding <= `URD_RESET_BYTE;
         fifoControl <= `URD_RESET_BYTE;
         txHoldingLoad <= 1'b0;
         fifoControlLoad <= 1'b0;
      end else begin
         txHoldingLoad <= 1'b0;
         fifoControlLoad <= 1'b0;
         if (writeStart) begin
            case (writeSel)
               `URD_SEL_TXHOLD: begin
                  txHolding <= dataIn;
                  txHoldingLoad <= 1'b1;
               end
               `URD_SEL_DIVLO: begin
                  divLo_q <= dataIn;
               end
               `URD_SEL_DIVHI: begin
                  divHi_q <= dataIn;
               end
               `URD_SEL_INTEN: begin
                  intEn_q <= dataIn;
               end
               `URD_SEL_FIFOCTL: begin
                  fifoControl <= dataIn;
                  fifoControlLoad <= 1'b1;
               end
               `URD_SEL_LINECTL: begin
                  lineCtl_q <= dataIn;
               end
               `URD_SEL_ENHFUNC: begin
                  enhFunc_q <= dataIn;
               end
               default: begin
                  // Unmapped address: write dropped
                  enhFunc_q <= enhFunc_q;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Reads

   // Data captured at strobe start and held, so a slow host sees a stable byte
   always @(posedge clk) begin
      if (!nrst) begin
         dataOut <= `URD_READ_NONE;
         dataOe <= 1'b0;
         rxHoldingRead <= 1'b0;
         interruptStatusRead <= 1'b0;
      end else begin
         dataOe <= readAct;
         rxHoldingRead <= 1'b0;
         interruptStatusRead <= 1'b0;
         if (readStart) begin
            case (readSel)
               `URD_SEL_RXHOLD: begin
                  dataOut <= rxHoldingIn;
                  rxHoldingRead <= 1'b1;
               end
               `URD_SEL_DIVLO: dataOut <= divLo_q;
               `URD_SEL_DIVHI: dataOut <= divHi_q;
               `URD_SEL_REVISION: dataOut <= `URD_REVISION_CODE;
               `URD_SEL_DEVID: dataOut <= `URD_DEVICE_ID_CODE;
               `URD_SEL_INTEN: dataOut <= intEn_q;
               `URD_SEL_INTSTAT: begin
                  dataOut <= interruptStatusIn;
                  interruptStatusRead <= 1'b1;
               end
               `URD_SEL_LINECTL: dataOut <= lineCtl_q;
               `URD_SEL_ENHFUNC: dataOut <= enhFunc_q;
               default: dataOut <= `URD_READ_NONE;
            endcase
         end
      end
   end

   assign divisorLow = divLo_q;
   assign divisorHigh = divHi_q;
   assign interruptEnable = intEn_q;
   assign lineControl = lineCtl_q;
   assign enhancedFunction = enhFunc_q;

endmodule

`default_nettype wire

//--- testbench/urd_register_decode_checker.sv
`default_nettype none
module urd_register_decode_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic csN,
   input wire logic iorN,
   input wire logic iowN,
   input wire logic [2:0] addr,
   input wire logic [7:0] dataIn,
   input wire logic dataOe,
   input wire logic rxHoldingRead,
   input wire logic interruptStatusRead,
   input wire logic [7:0] txHolding,
   input wire logic txHoldingLoad,
   input wire logic fifoControlLoad,
   input wire logic [7:0] lineControl,
   input wire logic [7:0] enhancedFunction
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire rd = !csN && !iorN;
   wire wr = !csN && !iowN;
   wire dl = lineControl[7];
   wire enh = lineControl == 8'hbf;
   chk_oe_read: assert property (rd |=> dataOe) else $error("bus not driven");
   chk_idle_quiet: assert property (csN |=> !dataOe && !rxHoldingRead && !txHoldingLoad && !fifoControlLoad)
      else $error("deselected activity");
   chk_rx_pulse: assert property ($rose(rd) && addr == 3'h0 && !dl |=> rxHoldingRead)
      else $error("no rx pulse");
   chk_tx_load: assert property ($rose(wr) && addr == 3'h0 && !dl |=>
      txHoldingLoad && txHolding == $past(dataIn))
      else $error("tx not loaded");
   chk_div_quiet: assert property ($rose(rd) && addr == 3'h0 && dl |=> !rxHoldingRead)
      else $error("rx pulse");
   chk_stat_pulse: assert property ($rose(rd) && addr == 3'h2 && !enh |=> interruptStatusRead)
      else $error("no pulse");
   chk_fifo_load: assert property ($rose(wr) && addr == 3'h2 && !enh |=> fifoControlLoad)
      else $error("no fifo load");
   chk_enh_steer: assert property ($rose(wr) && addr == 3'h2 && enh |=>
      !fifoControlLoad && enhancedFunction == $past(dataIn))
      else $error("enhanced not loaded");
   chk_line_write: assert property ($rose(wr) && addr == 3'h3 |=> lineControl == $past(dataIn))
      else $error("line");
   cover property ($rose(wr) && enh);
   cover property ($rose(rd) && dl);
   cover property (fifoControlLoad);
endmodule
bind urd_register_decode urd_register_decode_checker u_urd_register_decode_checker (.clk, .nrst, .csN, .iorN,
   .iowN, .addr, .dataIn, .dataOe, .rxHoldingRead, .interruptStatusRead, .txHolding, .txHoldingLoad,
   .fifoControlLoad, .lineControl, .enhancedFunction);
`default_nettype wire

//--- testbench/urd_host_model.sv
`default_nettype none
module urd_host_model (
   input wire logic clk,
   output logic csN,
   output logic iorN,
   output logic iowN,
   output logic [2:0] addr,
   output logic [7:0] dataIn,
   input wire logic [7:0] dataOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {csN, iorN, iowN, addr, dataIn} = {3'b111, 3'h0, 8'h00};
   end
   // One access per call; strobes idle a cycle after, released data inverted
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic c, output logic [7:0] q);
      @(posedge clk) #1;
      {csN, iorN, iowN, addr, dataIn} = {c, w, !w, a, d};
      @(posedge clk) #1;
      q = dataOut;
      {csN, iorN, iowN, dataIn} = {3'b111, ~d};
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_urd_register_decode.sv
`include "urd_regs.vh"
`default_nettype none
module tb_urd_register_decode;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, csN, iorN, iowN, dataOe, rxHoldingRead, interruptStatusRead, txHoldingLoad, fifoControlLoad;
   logic [2:0] addr;
   logic [7:0] dataIn, dataOut, txHolding, fifoControl, divisorLow, divisorHigh, interruptEnable, q;
   logic [7:0] lineControl, enhancedFunction;
   logic [7:0] rxHoldingIn = 8'h3c;
   logic [7:0] interruptStatusIn = 8'hc3;
   int mismatches = 0;
   int n_compared = 0;
   urd_register_decode u_urd_register_decode (.clk(clk), .nrst(nrst), .csN(csN), .iorN(iorN), .iowN(iowN),
      .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .rxHoldingIn(rxHoldingIn),
      .interruptStatusIn(interruptStatusIn), .rxHoldingRead(rxHoldingRead),
      .interruptStatusRead(interruptStatusRead), .txHolding(txHolding), .txHoldingLoad(txHoldingLoad),
      .fifoControl(fifoControl), .fifoControlLoad(fifoControlLoad), .divisorLow(divisorLow),
      .divisorHigh(divisorHigh), .interruptEnable(interruptEnable), .lineControl(lineControl),
      .enhancedFunction(enhancedFunction));
   urd_host_model u_urd_host_model (.clk, .csN, .iorN, .iowN, .addr, .dataIn, .dataOut);
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic c = 1'b0);
      u_urd_host_model.acc(1'b1, a, d, c, q);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm, input logic c = 1'b0);
      u_urd_host_model.acc(1'b0, a, 8'h00, c, q);
      if (!c) check(nm, q, e);
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      nrst = 0;
      repeat (4) @(posedge clk);
      #1 nrst = 1;
      rd(3'h3, 8'h00, "line");
      rd(3'h0, 8'h3c, "rx");
      rd(3'h2, 8'hc3, "status");
      wr(3'h0, 8'h11);
      check("tx", txHolding, 8'h11);
      wr(3'h1, 8'h22);
      rd(3'h1, 8'h22, "int enable");
      wr(3'h2, 8'h33);
      check("fifo", fifoControl, 8'h33);
      wr(3'h3, 8'h80);
      rd(3'h0, `URD_REVISION_CODE, "revision");
      rd(3'h1, `URD_DEVICE_ID_CODE, "id");
      wr(3'h0, 8'h44);
      rd(3'h0, 8'h44, "div low");
      rd(3'h1, 8'h00, "div high");
      wr(3'h1, 8'h66);
      rd(3'h1, 8'h66, "div high");
      check("div low out", divisorLow, 8'h44);
      check("div high out", divisorHigh, 8'h66);
      check("int enable", interruptEnable, 8'h22);
      wr(3'h3, 8'hbf);
      wr(3'h2, 8'h55);
      rd(3'h2, 8'h55, "enhanced");
      check("enhanced out", enhancedFunction, 8'h55);
      check("fifo", fifoControl, 8'h33);
      rd(3'h3, 8'hbf, "line");
      wr(3'h3, 8'h00, 1'b1);
      check("line", lineControl, 8'hbf);
      rd(3'h3, 8'h00, "", 1'b1);
      check("drive", {7'h00, dataOe}, 8'h00);
      rd(3'h5, 8'h00, "unmapped");
      tally_and_finish;
   end
endmodule
`default_nettype wire
